// *** hw/dram_pkg.sv ***
// constants, types and reset values of the strobe-driven dram controller
//
// Behaviour
// - row address set up, row strobe low, row held, then column and column strobe.
// - page mode keeps the row strobe low and pulses the column strobe per access.
// - write strobe before column strobe is early write, data valid at that edge.
// - with early writes only, data in and data out may share one wire.
// - each of the 128 rows is refreshed at least once every two milliseconds.
// - eight refreshing cycles are issued after power-up before normal use.
// - on a supply fault both strobes are driven to their inactive high level.
package dram_pkg;

  localparam int ROW_W      = 7;
  localparam int ADDR_W     = 14;
  localparam int ROW_LSB    = 7;
  localparam int ROWS       = 128;
  localparam int CLK_MHZ    = 50;
  localparam int CNT_W      = 8;
  localparam int RAS_TIME_W = 10;
  localparam int REF_CNT_W  = 10;

  // device timing in ns, slowest speed grade
  localparam int RAH_NS     = 35;
  localparam int CP_NS      = 100;
  localparam int RP_NS      = 150;
  localparam int RAS_NS     = 250;
  localparam int CAC_NS     = 165;
  localparam int RAC_NS     = 250;
  localparam int RAS_MAX_NS = 10000;
  localparam int REF_WIN_US = 2000;
  localparam int INIT_REFRESHES = 8;
  // three sync stages plus the agreement filter
  localparam int SYNC_LAT   = 4;

  function automatic int cyc_up(input int ns);
    cyc_up = (ns * CLK_MHZ + 999) / 1000;
  endfunction

  function automatic int cyc_down(input int ns);
    cyc_down = (ns * CLK_MHZ) / 1000;
  endfunction

  localparam int ROW_HOLD_I  = cyc_up(RAH_NS);
  localparam int CP_I        = cyc_up(CP_NS);
  localparam int RP_I        = cyc_up(RP_NS);
  localparam int RAS_I       = cyc_up(RAS_NS);
  // row strobe fall to column strobe fall
  localparam int RCD_I       = ROW_HOLD_I + 1;
  // read data settles on the later of the row and column access times
  localparam int ACC_I       = (cyc_up(RAC_NS) - RCD_I > cyc_up(CAC_NS))
                               ? cyc_up(RAC_NS) - RCD_I : cyc_up(CAC_NS);
  localparam int CAS_HOLD_I  = ACC_I + SYNC_LAT;
  localparam int RAS_MAX_I   = cyc_down(RAS_MAX_NS);
  localparam int PAGE_CYC_I  = CP_I + CAS_HOLD_I + 2;
  localparam int REF_ROW_I   = (REF_WIN_US * CLK_MHZ) / ROWS;
  // worst wait from a pending refresh to its row strobe
  localparam int REF_LAT_I   = 64;

  localparam logic [CNT_W-1:0] ROW_HOLD_LD = CNT_W'(ROW_HOLD_I - 1);
  localparam logic [CNT_W-1:0] CP_LD       = CNT_W'(CP_I - 1);
  localparam logic [CNT_W-1:0] RP_LD       = CNT_W'(RP_I - 1);
  localparam logic [CNT_W-1:0] RAS_LD      = CNT_W'(RAS_I - 1);
  localparam logic [CNT_W-1:0] CAS_HOLD_LD = CNT_W'(CAS_HOLD_I - 1);
  localparam logic [RAS_TIME_W-1:0] PAGE_LIMIT = RAS_TIME_W'(RAS_MAX_I - PAGE_CYC_I);
  localparam logic [REF_CNT_W-1:0]  REF_TICK_LD = REF_CNT_W'(REF_ROW_I - REF_LAT_I - 1);
  localparam logic [REF_CNT_W-1:0]  REF_ROW_CYC = REF_CNT_W'(REF_ROW_I);
  localparam logic [3:0] INIT_LAST = 4'(INIT_REFRESHES - 1);

  typedef enum logic [2:0] {
    IDLE, SETUP, ROW, COL, CAS_ACT, CAS_PRE, REFRESH, PRECH
  } state_t;

  typedef struct packed {
    state_t                  state;
    logic [CNT_W-1:0]        cnt;
    logic [RAS_TIME_W-1:0]   ras_time;
    logic                    is_ref;
    logic                    is_write;
    logic [ROW_W-1:0]        row;
    logic [ROW_W-1:0]        col;
    logic                    wdata;
    logic                    ras_n;
    logic                    cas_n;
    logic                    we_n;
    logic [ROW_W-1:0]        addr;
    logic                    req_ack;
    logic                    resp_valid;
    logic                    rdata;
    logic [2:0]              dq_sync;
    logic                    dq_filt;
    logic [2:0]              flt_sync;
    logic                    fault;
    logic                    ref_ack;
    logic                    init_done;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{state: IDLE, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                 default: '0};

  typedef struct packed {
    logic [REF_CNT_W-1:0] cnt;
    logic                 pending;
    logic [ROW_W-1:0]     row;
    logic [3:0]           init_cnt;
    logic                 init_done;
    logic [REF_CNT_W-1:0] since_ack;
  } sched_t;

  localparam sched_t SCHED_RST = '{cnt: REF_TICK_LD, pending: 1'b1, default: '0};

endpackage

// *** hw/refresh_if.sv ***
// refresh request and acknowledge between scheduler and strobe sequencer
`timescale 1ns/100ps
interface refresh_if;
  logic                       pending;
  logic [dram_pkg::ROW_W-1:0] row;
  logic                       init_done;
  logic                       ack;

  modport sched (output pending, output row, output init_done, input ack);
  modport ctrl  (input pending, input row, input init_done, output ack);
endinterface

// *** hw/refresh_sched.sv ***
// refresh timer, row counter and power-up refresh count
`timescale 1ns/100ps
module refresh_sched (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // sequencer side
  refresh_if.sched  rf
);

  dram_pkg::sched_t r_reg;
  dram_pkg::sched_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.since_ack = (r_reg.since_ack == '1) ? r_reg.since_ack : r_reg.since_ack + 1'b1;
    if (r_reg.cnt == '0) begin
      r_next.cnt = dram_pkg::REF_TICK_LD;
    end else begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
    if (rf.ack) begin
      r_next.row       = r_reg.row + 1'b1;
      r_next.since_ack = '0;
      r_next.pending   = 1'b0;
      if (!r_reg.init_done) begin
        r_next.init_cnt = r_reg.init_cnt + 1'b1;
        r_next.pending  = (r_reg.init_cnt != dram_pkg::INIT_LAST);
        r_next.init_done = (r_reg.init_cnt == dram_pkg::INIT_LAST);
      end
    end
    // a tick in the acknowledge cycle still leaves a refresh pending
    if (r_reg.cnt == '0) begin
      r_next.pending = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r_reg <= dram_pkg::SCHED_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rf.pending   = r_reg.pending;
  assign rf.row       = r_reg.row;
  assign rf.init_done = r_reg.init_done;

  refresh_gap_a: assert property (@(posedge clock) disable iff (rst)
    r_reg.init_done |-> r_reg.since_ack < dram_pkg::REF_ROW_CYC)
    else $error("row refresh gap too long");

  init_count_a: assert property (@(posedge clock) disable iff (rst)
    $rose(r_reg.init_done) |-> $past(rf.ack) && $past(r_reg.init_cnt) == dram_pkg::INIT_LAST)
    else $error("init done without eight refreshes");

  init_cover_c: cover property (@(posedge clock) disable iff (rst) $rose(r_reg.init_done));

endmodule

// *** hw/dram_ctrl.sv ***
// strobe sequencer that drives the dynamic memory pins
`timescale 1ns/100ps
module dram_ctrl (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst,
  // user request
  input  wire logic                          req_valid,
  input  wire logic                          req_write,
  input  wire logic [dram_pkg::ADDR_W-1:0]   req_addr,
  input  wire logic                          req_wdata,
  output logic                               req_ack,
  output logic                               init_done,
  // user response
  output logic                               resp_valid,
  output logic                               resp_rdata,
  // memory pins
  output logic                               ras_n,
  output logic                               cas_n,
  output logic                               we_n,
  output logic [dram_pkg::ROW_W-1:0]         mem_addr,
  output logic                               write_data_in,
  input  wire logic                          read_data_out,
  // supply monitor
  input  wire logic                          supply_fault
);

  dram_pkg::ctrl_t r_reg;
  dram_pkg::ctrl_t r_next;
  refresh_if       rf ();
  logic            page_hit;

  refresh_sched u_sched (
    .clock (clock),
    .rst   (rst),
    .rf    (rf)
  );

  assign rf.ack = r_reg.ref_ack;

  // next access may stay in the open row
  assign page_hit = req_valid && !rf.pending && !r_reg.is_ref
                    && (req_addr[dram_pkg::ADDR_W-1:dram_pkg::ROW_LSB] == r_reg.row)
                    && (r_reg.ras_time < dram_pkg::PAGE_LIMIT);

  always_comb begin
    r_next = r_reg;
    r_next.req_ack    = 1'b0;
    r_next.resp_valid = 1'b0;
    r_next.ref_ack    = 1'b0;
    r_next.init_done  = rf.init_done;
    r_next.dq_sync    = {r_reg.dq_sync[1:0], read_data_out};
    r_next.flt_sync   = {r_reg.flt_sync[1:0], supply_fault};
    if (r_reg.dq_sync[2] == r_reg.dq_sync[1]) begin
      r_next.dq_filt = r_reg.dq_sync[2];
    end
    if (r_reg.flt_sync[2] == r_reg.flt_sync[1]) begin
      r_next.fault = r_reg.flt_sync[2];
    end
    r_next.cnt = (r_reg.cnt == '0) ? r_reg.cnt : r_reg.cnt - 1'b1;
    r_next.ras_time = r_reg.ras_n ? '0 : r_reg.ras_time + 1'b1;
    case (r_reg.state)
      dram_pkg::IDLE: begin
        if (rf.pending) begin
          r_next.is_ref = 1'b1;
          r_next.addr   = rf.row;
          r_next.state  = dram_pkg::SETUP;
        end else if (req_valid && rf.init_done) begin
          r_next.is_ref   = 1'b0;
          r_next.is_write = req_write;
          r_next.row      = req_addr[dram_pkg::ADDR_W-1:dram_pkg::ROW_LSB];
          r_next.col      = req_addr[dram_pkg::ROW_LSB-1:0];
          r_next.wdata    = req_wdata;
          r_next.addr     = req_addr[dram_pkg::ADDR_W-1:dram_pkg::ROW_LSB];
          r_next.req_ack  = 1'b1;
          r_next.state    = dram_pkg::SETUP;
        end
      end
      dram_pkg::SETUP: begin
        r_next.ras_n = 1'b0;
        if (r_reg.is_ref) begin
          r_next.ref_ack = 1'b1;
          r_next.cnt     = dram_pkg::RAS_LD;
          r_next.state   = dram_pkg::REFRESH;
        end else begin
          r_next.cnt   = dram_pkg::ROW_HOLD_LD;
          r_next.state = dram_pkg::ROW;
        end
      end
      dram_pkg::ROW: begin
        if (r_reg.cnt == '0) begin
          r_next.addr  = r_reg.col;
          // write strobe leads the column strobe: early writes only
          r_next.we_n  = !r_reg.is_write;
          r_next.state = dram_pkg::COL;
        end
      end
      dram_pkg::COL: begin
        r_next.cas_n = 1'b0;
        r_next.cnt   = dram_pkg::CAS_HOLD_LD;
        r_next.state = dram_pkg::CAS_ACT;
      end
      dram_pkg::CAS_ACT: begin
        if (r_reg.cnt == '0) begin
          r_next.cas_n      = 1'b1;
          r_next.we_n       = 1'b1;
          r_next.resp_valid = 1'b1;
          r_next.rdata      = r_reg.is_write ? r_reg.wdata : r_reg.dq_filt;
          if (page_hit) begin
            r_next.is_write = req_write;
            r_next.col      = req_addr[dram_pkg::ROW_LSB-1:0];
            r_next.wdata    = req_wdata;
            r_next.req_ack  = 1'b1;
            r_next.cnt      = dram_pkg::CP_LD;
            r_next.state    = dram_pkg::CAS_PRE;
          end else begin
            r_next.ras_n = 1'b1;
            r_next.cnt   = dram_pkg::RP_LD;
            r_next.state = dram_pkg::PRECH;
          end
        end
      end
      dram_pkg::CAS_PRE: begin
        if (r_reg.cnt == '0) begin
          r_next.addr  = r_reg.col;
          r_next.we_n  = !r_reg.is_write;
          r_next.state = dram_pkg::COL;
        end
      end
      dram_pkg::REFRESH: begin
        if (r_reg.cnt == '0) begin
          r_next.ras_n  = 1'b1;
          r_next.is_ref = 1'b0;
          r_next.cnt    = dram_pkg::RP_LD;
          r_next.state  = dram_pkg::PRECH;
        end
      end
      dram_pkg::PRECH: begin
        if (r_reg.cnt == '0) begin
          r_next.state = dram_pkg::IDLE;
        end
      end
      default: begin
        r_next.state = dram_pkg::IDLE;
      end
    endcase
    // supply fault parks every strobe high and aborts the cycle;
    // a full precharge follows so a short fault cannot cut the row strobe high time
    if (r_reg.fault) begin
      r_next.ras_n      = 1'b1;
      r_next.cas_n      = 1'b1;
      r_next.we_n       = 1'b1;
      r_next.is_ref     = 1'b0;
      r_next.req_ack    = 1'b0;
      r_next.resp_valid = 1'b0;
      r_next.ref_ack    = 1'b0;
      r_next.cnt        = dram_pkg::RP_LD;
      r_next.state      = dram_pkg::PRECH;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r_reg <= dram_pkg::CTRL_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign req_ack       = r_reg.req_ack;
  assign init_done     = r_reg.init_done;
  assign resp_valid    = r_reg.resp_valid;
  assign resp_rdata    = r_reg.rdata;
  assign ras_n         = r_reg.ras_n;
  assign cas_n         = r_reg.cas_n;
  assign we_n          = r_reg.we_n;
  assign mem_addr      = r_reg.addr;
  assign write_data_in = r_reg.wdata;

  row_setup_a: assert property (@(posedge clock) disable iff (rst)
    $fell(r_reg.ras_n) |-> $stable(r_reg.addr) ##1 $stable(r_reg.addr))
    else $error("row address moved around row strobe fall");

  cas_after_ras_a: assert property (@(posedge clock) disable iff (rst)
    $fell(r_reg.cas_n) |-> !r_reg.ras_n && !$past(r_reg.ras_n, 3))
    else $error("column strobe too soon after row strobe");

  early_write_a: assert property (@(posedge clock) disable iff (rst)
    $fell(r_reg.cas_n) && !r_reg.we_n |-> !$past(r_reg.we_n) && $stable(r_reg.wdata))
    else $error("write strobe not ahead of column strobe");

  page_row_a: assert property (@(posedge clock) disable iff (rst)
    r_reg.state == dram_pkg::CAS_PRE && !r_reg.fault |-> !r_reg.ras_n && r_reg.cas_n)
    else $error("row strobe dropped inside page");

  read_we_a: assert property (@(posedge clock) disable iff (rst)
    !r_reg.cas_n && !r_reg.is_write |-> r_reg.we_n)
    else $error("write strobe low in read cycle");

  ras_only_a: assert property (@(posedge clock) disable iff (rst)
    r_reg.state == dram_pkg::REFRESH |-> r_reg.cas_n && r_reg.we_n)
    else $error("refresh cycle with column strobe");

  fault_idle_a: assert property (@(posedge clock) disable iff (rst)
    r_reg.fault |=> r_reg.ras_n && r_reg.cas_n)
    else $error("strobes active during supply fault");

  init_gate_a: assert property (@(posedge clock) disable iff (rst)
    r_reg.req_ack |-> rf.init_done)
    else $error("request taken before power-up refreshes");

  cas_width_a: assert property (@(posedge clock) disable iff (rst)
    $rose(r_reg.cas_n) && !$past(r_reg.fault)
      |-> !$past(r_reg.cas_n, 8) && !$past(r_reg.cas_n, 13))
    else $error("column strobe pulse too short");

  read_cover_c:  cover property (@(posedge clock) disable iff (rst)
    r_reg.resp_valid && !r_reg.is_write);
  write_cover_c: cover property (@(posedge clock) disable iff (rst)
    $fell(r_reg.cas_n) && !r_reg.we_n);
  page_cover_c:  cover property (@(posedge clock) disable iff (rst)
    r_reg.state == dram_pkg::CAS_PRE);
  ref_cover_c:   cover property (@(posedge clock) disable iff (rst)
    r_reg.ref_ack && r_reg.init_done);

endmodule

// *** test/dram_model.sv ***
// behavioural model of the 16k x 1 strobe-driven dynamic memory
`timescale 1ns/100ps
module dram_model #(
  parameter real ACC_ROW_NS = 250.0,
  parameter real ACC_COL_NS = 165.0,
  parameter real REF_GAP_NS = 15625.0
) (
  // memory pins
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic [dram_pkg::ROW_W-1:0] mem_addr,
  input  wire logic                       write_data_in,
  output logic                            read_data_out,
  // protocol observations
  output int                              viol,
  output int                              refreshes
);
  logic                       cells [0:(1<<dram_pkg::ADDR_W)-1];
  logic [dram_pkg::ROW_W-1:0] row = '0;
  logic [dram_pkg::ROW_W-1:0] col = '0;
  logic [dram_pkg::ROW_W-1:0] ref_row = '0;
  logic                       drive = 1'b0;
  logic                       dout = 1'b0;
  logic                       flip = 1'b0;
  logic                       had_col = 1'b0;
  logic                       had_ref = 1'b0;
  logic                       used = 1'b0;
  realtime                    ras_t = 0.0;
  realtime                    ref_t = 0.0;
  realtime                    acc;

  initial viol = 0;
  initial refreshes = 0;
  // a floating output shows a pattern that keeps changing
  always #7 flip = ~flip;
  assign read_data_out = drive ? dout : flip;

  always @(negedge ras_n) begin
    row = mem_addr;
    ras_t = $realtime;
    had_col = 1'b0;
    refreshes++;
  end

  // row-strobe-only cycles must walk the rows in step and in time
  always @(posedge ras_n) begin
    if (!had_col && refreshes > 0) begin
      if (had_ref && (ras_t - ref_t > REF_GAP_NS || row !== ref_row + 7'h01)) viol++;
      had_ref = 1'b1;
      ref_t = ras_t;
      ref_row = row;
    end
  end

  always @(mem_addr) begin
    if (!ras_n && cas_n && $realtime - ras_t < dram_pkg::RAH_NS) viol++;
  end

  always @(negedge cas_n) begin
    if (!ras_n) begin
      col = mem_addr;
      had_col = 1'b1;
      if (!used && refreshes <= dram_pkg::INIT_REFRESHES) viol++;
      used = 1'b1;
      if (!we_n) begin
        cells[{row, col}] = write_data_in;
      end else begin
        acc = ras_t + ACC_ROW_NS - $realtime;
        if (acc < ACC_COL_NS) acc = ACC_COL_NS;
        #(acc);
        // a write strobe during access leaves the output off
        if (!cas_n && we_n) begin
          dout = cells[{row, col}];
          drive = 1'b1;
        end
      end
    end
  end

  // a late write strobe is the data strobe
  always @(negedge we_n) begin
    if (!ras_n && !cas_n) cells[{row, col}] = write_data_in;
  end

  always @(posedge cas_n) drive = 1'b0;
endmodule

// *** test/test_dram_ctrl.sv ***
// self-checking bench for the strobe sequencer and its memory model
`timescale 1ns/100ps
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %s expected %0h seen %0h", what, exp, got); end end
module test_dram_ctrl;
  localparam int LIMIT = 30000;
  logic                        clock;
  logic                        rst;
  logic                        req_valid;
  logic                        req_write;
  logic [dram_pkg::ADDR_W-1:0] req_addr;
  logic                        req_wdata;
  logic                        supply_fault;
  logic                        req_ack, init_done, resp_valid, resp_rdata;
  logic                        ras_n, cas_n, we_n, write_data_in, read_data_out;
  logic [dram_pkg::ROW_W-1:0]  mem_addr;
  logic                        rd;
  int                          miscompares = 0;
  int                          n_checks = 0;
  int                          cycles = 0;
  int                          ras_rises = 0;
  int                          viol, refreshes;

  dram_ctrl i_dram_ctrl (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ack(req_ack),
    .init_done(init_done), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mem_addr(mem_addr),
    .write_data_in(write_data_in), .read_data_out(read_data_out),
    .supply_fault(supply_fault));
  dram_model i_dram_model (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mem_addr(mem_addr),
    .write_data_in(write_data_in), .read_data_out(read_data_out), .viol(viol),
    .refreshes(refreshes));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge ras_n) ras_rises++;
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      $display("[ERR] timeout expected 0 seen %0d", cycles);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic until_high(ref logic s, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (s !== 1'b1 && n < lim);
  endtask

  // request held until acknowledged, then dropped; row and column checked on the pins
  task automatic access(input logic wr, input logic [13:0] a, input logic d, output logic q);
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    until_high(req_ack, 2000);
    `CHK("req_ack", 1'b1, req_ack)
    @(posedge clock);
    req_valid <= 1'b0;
    @(negedge clock);
    `CHK("row on pins", a[13:7], mem_addr)
    while (cas_n !== 1'b0 && ras_n === 1'b0) @(negedge clock);
    `CHK("column on pins", a[6:0], mem_addr)
    `CHK("early write strobe", ~wr, we_n)
    until_high(resp_valid, 40);
    `CHK("resp_valid", 1'b1, resp_valid)
    q = resp_rdata;
  endtask

  task automatic t_init();
    @(negedge clock);
    `CHK("init_done at reset", 1'b0, init_done)
    `CHK("ras_n at reset", 1'b1, ras_n)
    until_high(init_done, 400);
    `CHK("init_done", 1'b1, init_done)
    `CHK("power-up refreshes", 1'b1, refreshes >= dram_pkg::INIT_REFRESHES)
  endtask

  // single-bit address neighbours at bits 0, 6, 7 and 13 expose a lost bit among those, but not a swapped pair
  task automatic t_rw();
    logic [13:0] adr [6];
    logic        dat [6];
    adr = '{14'h0000, 14'h0001, 14'h0040, 14'h0080, 14'h2000, 14'h3FFF};
    dat = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    foreach (adr[i]) access(1'b1, adr[i], dat[i], rd);
    foreach (adr[i]) begin
      access(1'b0, adr[i], 1'b0, rd);
      `CHK("read data", dat[i], rd)
      access(1'b0, adr[i], 1'b0, rd);
      `CHK("read again", dat[i], rd)
    end
  endtask

  // two reads of one row under one row strobe, right after a refresh
  task automatic t_page();
    int r0;
    int n;
    r0 = refreshes;
    while (refreshes == r0) @(negedge clock);
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= 1'b0;
    req_addr <= 14'h0000;
    until_high(req_ack, 2000);
    @(posedge clock);
    req_addr <= 14'h0001;
    until_high(resp_valid, 40);
    `CHK("page read 1", 1'b1, resp_rdata)
    `CHK("page ack", 1'b1, req_ack)
    r0 = ras_rises;
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (resp_valid !== 1'b1 && n < 40);
    `CHK("page read 2", 1'b0, resp_rdata)
    `CHK("page spacing", dram_pkg::CP_I + 1 + dram_pkg::CAS_HOLD_I, n)
    `CHK("row strobe rises", 1, ras_rises - r0)
  endtask

  task automatic t_fault();
    int n;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= 1'b0;
    req_addr <= 14'h3FFF;
    until_high(req_ack, 2000);
    @(posedge clock);
    req_valid <= 1'b0;
    while (cas_n !== 1'b0) @(negedge clock);
    @(posedge clock);
    supply_fault <= 1'b1;
    repeat (6) @(negedge clock);
    for (n = 0; n < 10; n++) begin
      `CHK("strobes off in fault", 2'b11, {ras_n, cas_n})
      `CHK("no resp in fault", 1'b0, resp_valid)
      @(negedge clock);
    end
    @(posedge clock);
    supply_fault <= 1'b0;
    repeat (8) @(posedge clock);
    access(1'b0, 14'h3FFF, 1'b0, rd);
    `CHK("read after fault", 1'b1, rd)
  endtask

  task automatic t_refresh();
    int r0;
    r0 = refreshes;
    repeat (20000) @(posedge clock);
    @(negedge clock);
    `CHK("refresh count", 1'b1, refreshes - r0 >= 20000 / 781)
    `CHK("protocol faults", 0, viol)
  endtask

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = 1'b0;
    supply_fault = 1'b0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_init();
    t_rw();
    t_page();
    t_fault();
    t_refresh();
    tally_and_finish();
  end
endmodule
